// *** src/pll_cfg_pkg.sv ***
// Purpose: Shared constants for the divider and output-9 configuration bank
// Assumes: Serial framing is done outside; words arrive as 32 parallel bits
// Notes: Bit positions are serial word positions, storage bit plus four
`default_nettype none
package pll_cfg_pkg;
  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int DIV_W = 14;
  localparam logic [3:0] OUT9_REG_ADDR = 4'h9;
  localparam logic [3:0] PLL_DIVIDER_MODULI = 4'ha;
  localparam int REF_DIV_LSB = 4;
  localparam int FB_DIV_LSB = 18;
  localparam int POS_X_BIT = 26;
  localparam int POS_Y_BIT = 27;
  localparam int NEG_X_BIT = 28;
  localparam int NEG_Y_BIT = 29;
  localparam int BUF_X_BIT = 30;
  localparam int BUF_Y_BIT = 31;
  // ------------------------------------------------------------------
  // Encodings, as {x, y}
  // ------------------------------------------------------------------
  localparam logic [1:0] PIN_ACTIVE = 2'h0;
  localparam logic [1:0] PIN_OFF = 2'h1;
  localparam logic [1:0] PIN_INVERT = 2'h2;
  localparam logic [1:0] PIN_LOW = 2'h3;
  localparam logic [1:0] BUF_SINGLE = 2'h0;
  localparam logic [1:0] BUF_LOW_SWING = 2'h3;
  // ------------------------------------------------------------------
  // Values after reset, before the non-volatile load
  // ------------------------------------------------------------------
  localparam logic [13:0] REF_DIV_RST = 14'h0000;
  localparam logic [13:0] FB_DIV_RST = 14'h0000;
  localparam logic [1:0] PIN_MODE_RST = 2'h0;
  localparam logic [1:0] BUF_TYPE_RST = 2'h0;
endpackage : pll_cfg_pkg
`default_nettype wire

// *** src/pin_mode_if.sv ***
// Purpose: Carries one output-9 pin mode and its decoded controls
// Assumes: One instance per pin
// Notes: Mode is {x, y}
`default_nettype none
interface pin_mode_if;
  logic [1:0] mode;
  logic enable;
  logic drive;
  logic invert;
  logic force_low;
  modport ctrl (output mode, output enable,
                input drive, input invert, input force_low);
  modport dec (input mode, input enable,
               output drive, output invert, output force_low);
endinterface : pin_mode_if
`default_nettype wire

// *** src/pin_mode_decoder.sv ***
// Purpose: Decodes a two-bit single-ended pin mode into pin controls
// Assumes: Enable is high only while the buffer is single-ended
// Notes: Code 01 is treated as pin off
`default_nettype none
module pin_mode_decoder
  import pll_cfg_pkg::*;
(
  pin_mode_if.dec pin
);
  always_comb
  begin
    pin.drive = 1'b0;
    pin.invert = 1'b0;
    pin.force_low = 1'b0;
    if (pin.enable)
    begin
      case (pin.mode)
        PIN_ACTIVE: pin.drive = 1'b1;
        PIN_INVERT:
        begin
          pin.drive = 1'b1;
          pin.invert = 1'b1;
        end
        PIN_LOW: pin.force_low = 1'b1;
        default: pin.drive = 1'b0;
      endcase
    end
  end
endmodule : pin_mode_decoder
`default_nettype wire

// *** src/pll_divider_config_regs.sv ***
// Purpose: Holds divider moduli and output-9 type and pin modes
// Assumes: Words and non-volatile load arrive synchronous to sys_clk
// Notes: A load in the same cycle as a write wins over the write
`default_nettype none
module pll_divider_config_regs
  import pll_cfg_pkg::*;
#(
  parameter int DIV_BITS = DIV_W
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_wr_valid,
  input wire logic [31:0] cfg_wr_word,
  input wire logic cfg_rd_req,
  input wire logic [3:0] cfg_rd_addr,
  output logic cfg_rd_ack,
  output logic cfg_rd_hit,
  output logic [31:0] cfg_rd_word,
  input wire logic nv_load,
  input wire logic [13:0] nv_ref_div,
  input wire logic [13:0] nv_fb_div,
  input wire logic [5:0] nv_out9_bits,
  output logic [13:0] ref_div,
  output logic [13:0] fb_div,
  output logic [1:0] out9_buffer_type,
  output logic out9_single_ended,
  output logic out9_low_swing_diff,
  output logic out9_pos_drive,
  output logic out9_pos_invert,
  output logic out9_pos_force_low,
  output logic out9_neg_drive,
  output logic out9_neg_invert,
  output logic out9_neg_force_low
);
  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (DIV_BITS != DIV_W || 2 * DIV_BITS + ADDR_W != WORD_W)
  begin : g_bad_width
    $error("Divider width must fill the word beside the address");
  end

  typedef struct packed {
    logic [13:0] ref_div;
    logic [13:0] fb_div;
    logic [1:0] pos_mode;
    logic [1:0] neg_mode;
    logic [1:0] buf_type;
    logic rd_ack;
    logic rd_hit;
    logic [31:0] rd_word;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic wr_div;
  logic wr_out9;
  pin_mode_if pos_pin ();
  pin_mode_if neg_pin ();

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  // address decode
  assign wr_div = cfg_wr_valid && cfg_wr_word[3:0] == PLL_DIVIDER_MODULI;
  assign wr_out9 = cfg_wr_valid && cfg_wr_word[3:0] == OUT9_REG_ADDR;

  always_comb
  begin
    st_d = st_q;
    if (nv_load)
    begin
      st_d.ref_div = nv_ref_div;
      st_d.fb_div = nv_fb_div;
      st_d.pos_mode = {nv_out9_bits[0], nv_out9_bits[1]};
      st_d.neg_mode = {nv_out9_bits[2], nv_out9_bits[3]};
      st_d.buf_type = {nv_out9_bits[4], nv_out9_bits[5]};
    end
    else
    begin
      if (wr_div)
      begin
        st_d.ref_div = cfg_wr_word[REF_DIV_LSB +: 14];
        st_d.fb_div = cfg_wr_word[FB_DIV_LSB +: 14];
      end
      if (wr_out9)
      begin
        st_d.pos_mode = {cfg_wr_word[POS_X_BIT], cfg_wr_word[POS_Y_BIT]};
        st_d.neg_mode = {cfg_wr_word[NEG_X_BIT], cfg_wr_word[NEG_Y_BIT]};
        st_d.buf_type = {cfg_wr_word[BUF_X_BIT], cfg_wr_word[BUF_Y_BIT]};
      end
    end
    // Readback of a mapped address echoes it in the low bits; unmapped reads return zero
    st_d.rd_ack = cfg_rd_req;
    st_d.rd_hit = 1'b0;
    st_d.rd_word = 32'h0000_0000;
    if (cfg_rd_req)
    begin
      case (cfg_rd_addr)
        PLL_DIVIDER_MODULI:
        begin
          st_d.rd_hit = 1'b1;
          st_d.rd_word = {st_q.fb_div, st_q.ref_div, PLL_DIVIDER_MODULI};
        end
        OUT9_REG_ADDR:
        begin
          st_d.rd_hit = 1'b1;
          st_d.rd_word[3:0] = OUT9_REG_ADDR;
          st_d.rd_word[POS_X_BIT] = st_q.pos_mode[1];
          st_d.rd_word[POS_Y_BIT] = st_q.pos_mode[0];
          st_d.rd_word[NEG_X_BIT] = st_q.neg_mode[1];
          st_d.rd_word[NEG_Y_BIT] = st_q.neg_mode[0];
          st_d.rd_word[BUF_X_BIT] = st_q.buf_type[1];
          st_d.rd_word[BUF_Y_BIT] = st_q.buf_type[0];
        end
        default: st_d.rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '{ref_div: REF_DIV_RST, fb_div: FB_DIV_RST,
                 pos_mode: PIN_MODE_RST, neg_mode: PIN_MODE_RST,
                 buf_type: BUF_TYPE_RST, rd_ack: 1'b0, rd_hit: 1'b0,
                 rd_word: 32'h0000_0000};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Output 9 pin control
  // ------------------------------------------------------------------
  // single-ended gating
  assign out9_single_ended = st_q.buf_type == BUF_SINGLE;
  assign out9_low_swing_diff = st_q.buf_type == BUF_LOW_SWING;
  assign pos_pin.mode = st_q.pos_mode;
  assign pos_pin.enable = out9_single_ended;
  assign neg_pin.mode = st_q.neg_mode;
  assign neg_pin.enable = out9_single_ended;

  pin_mode_decoder u_pos_dec (
    .pin (pos_pin)
  );

  pin_mode_decoder u_neg_dec (
    .pin (neg_pin)
  );

  assign out9_pos_drive = pos_pin.drive;
  assign out9_pos_invert = pos_pin.invert;
  assign out9_pos_force_low = pos_pin.force_low;
  assign out9_neg_drive = neg_pin.drive;
  assign out9_neg_invert = neg_pin.invert;
  assign out9_neg_force_low = neg_pin.force_low;
  assign ref_div = st_q.ref_div;
  assign fb_div = st_q.fb_div;
  assign out9_buffer_type = st_q.buf_type;
  assign cfg_rd_ack = st_q.rd_ack;
  assign cfg_rd_hit = st_q.rd_hit;
  assign cfg_rd_word = st_q.rd_word;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  other_addr_keeps_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!nv_load && !(cfg_wr_valid && cfg_wr_word[3:0] == PLL_DIVIDER_MODULI))
    |=> $stable(ref_div) && $stable(fb_div))
    else $error("Divider changed without a divider word");
  unmapped_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (cfg_rd_req && cfg_rd_addr != PLL_DIVIDER_MODULI
     && cfg_rd_addr != OUT9_REG_ADDR)
    |=> cfg_rd_ack && !cfg_rd_hit && cfg_rd_word == 32'h0000_0000)
    else $error("Unmapped read not answered empty");
  read_answer_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !cfg_rd_req |=> !cfg_rd_ack && !cfg_rd_hit
      && cfg_rd_word == 32'h0000_0000)
    else $error("Read answer outside the cycle after a request");
  ref_div_load_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!nv_load && cfg_wr_valid && cfg_wr_word[3:0] == PLL_DIVIDER_MODULI)
    |=> ref_div == $past(cfg_wr_word[17:4]))
    else $error("Reference divider not taken from bits 4 to 17");
  nv_load_wins_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    nv_load |=> ref_div == $past(nv_ref_div) && fb_div == $past(nv_fb_div))
    else $error("Non-volatile load did not set the dividers");
  fb_div_load_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!nv_load && cfg_wr_valid && cfg_wr_word[3:0] == PLL_DIVIDER_MODULI)
    |=> fb_div == $past(cfg_wr_word[31:18]))
    else $error("Feedback divider not taken from bits 18 to 31");
  div_readback_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (cfg_rd_req && cfg_rd_addr == PLL_DIVIDER_MODULI)
    |=> cfg_rd_ack && cfg_rd_hit
      && cfg_rd_word == {$past(fb_div), $past(ref_div), PLL_DIVIDER_MODULI})
    else $error("Divider readback wrong");
  neg_pin_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (out9_single_ended && st_q.neg_mode == PIN_LOW)
    |-> out9_neg_force_low && !out9_neg_drive)
    else $error("Negative pin code 11 not forced low");
  neg_pin_inv_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (out9_single_ended && st_q.neg_mode == PIN_INVERT)
    |-> out9_neg_drive && out9_neg_invert && !out9_neg_force_low)
    else $error("Negative pin code 10 not inverted");
  pins_idle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (out9_buffer_type != BUF_SINGLE) |-> !(out9_pos_drive || out9_neg_drive
      || out9_pos_force_low || out9_neg_force_low))
    else $error("Pin mode acted outside single-ended type");
  pos_pin_inv_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!nv_load && cfg_wr_valid && cfg_wr_word[3:0] == OUT9_REG_ADDR
     && cfg_wr_word[31:26] == 6'h01)
    |=> out9_pos_invert && !out9_neg_invert && out9_single_ended)
    else $error("Positive pin invert code not applied alone");
  pos_pin_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (out9_single_ended && st_q.pos_mode == PIN_LOW)
    |-> out9_pos_force_low && !out9_pos_drive)
    else $error("Positive pin code 11 not forced low");
  buf_type_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!nv_load && cfg_wr_valid && cfg_wr_word[3:0] == OUT9_REG_ADDR
     && cfg_wr_word[31:30] == 2'h3)
    |=> out9_low_swing_diff && !out9_single_ended)
    else $error("Low-swing buffer type not selected");
endmodule : pll_divider_config_regs
`default_nettype wire

// *** verification/cfg_ctrl_model.sv ***
// Purpose: Stand-in for the serial configuration controller
// Assumes: Framing is done outside; words arrive whole
// Notes: Drives on the falling edge; released lines show inverse
`default_nettype none
module cfg_ctrl_model
(
  input wire logic sys_clk,
  output logic cfg_wr_valid,
  output logic [31:0] cfg_wr_word,
  output logic cfg_rd_req,
  output logic [3:0] cfg_rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cfg_wr_valid = 1'b0;
    cfg_wr_word = 32'h0;
    cfg_rd_req = 1'b0;
    cfg_rd_addr = 4'h0;
  end
  task automatic write(input logic [3:0] a, input logic [27:0] body);
    @(negedge sys_clk);
    cfg_wr_word = {body, a};
    cfg_wr_valid = 1'b1;
    @(negedge sys_clk);
    cfg_wr_valid = 1'b0;
    cfg_wr_word = ~cfg_wr_word;
  endtask : write
  task automatic read(input logic [3:0] a);
    @(negedge sys_clk);
    cfg_rd_addr = a;
    cfg_rd_req = 1'b1;
    @(negedge sys_clk);
    cfg_rd_req = 1'b0;
    cfg_rd_addr = ~a;
  endtask : read
endmodule : cfg_ctrl_model
`default_nettype wire

// *** verification/pll_divider_config_regs_tb.sv ***
// Purpose: Self-checking bench for the divider and output-9 bank
// Assumes: Read answer is visible at the falling edge after the take
// Notes: Expected values built from field layout only
`default_nettype none
module pll_divider_config_regs_tb
  import pll_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, nv_load, ack, hit, se, ls;
  logic [31:0] word;
  logic [13:0] nv_ref, nv_fb, ref_div, fb_div;
  logic [5:0] nv_o9;
  logic [1:0] btype;
  logic [2:0] pos, neg;
  logic wv, rq;
  logic [31:0] ww;
  logic [3:0] ra;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  cfg_ctrl_model i_ctrl (.sys_clk(sys_clk), .cfg_wr_valid(wv),
    .cfg_wr_word(ww), .cfg_rd_req(rq), .cfg_rd_addr(ra));
  pll_divider_config_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .cfg_wr_valid(wv), .cfg_wr_word(ww), .cfg_rd_req(rq),
    .cfg_rd_addr(ra), .cfg_rd_ack(ack), .cfg_rd_hit(hit),
    .cfg_rd_word(word), .nv_load(nv_load), .nv_ref_div(nv_ref),
    .nv_fb_div(nv_fb), .nv_out9_bits(nv_o9), .ref_div(ref_div),
    .fb_div(fb_div), .out9_buffer_type(btype), .out9_single_ended(se),
    .out9_low_swing_diff(ls), .out9_pos_drive(pos[2]),
    .out9_pos_invert(pos[1]), .out9_pos_force_low(pos[0]),
    .out9_neg_drive(neg[2]), .out9_neg_invert(neg[1]),
    .out9_neg_force_low(neg[0]));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic give_verdict();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic rd(input logic [3:0] a, input logic h, logic [31:0] w);
    i_ctrl.read(a);
    check("ack", ack, 1);
    check("hit", hit, h);
    check("word", word, w);
    @(negedge sys_clk);
    check("ack end", ack, 0);
    check("word end", word, 0);
  endtask : rd
  function automatic logic [5:0] f9(logic [1:0] p, n, b);
    return {b[0], b[1], n[0], n[1], p[0], p[1]};
  endfunction : f9
  function automatic logic [2:0] pin(logic [1:0] m, logic s);
    return !s ? 3'h0 : m == 2'h0 ? 3'h4 : m == 2'h2 ? 3'h6 :
      m == 2'h3 ? 3'h1 : 3'h0;
  endfunction : pin
  task automatic test_dividers();
    logic [27:0] t[3] = '{{14'h0, 14'h3fff}, {14'h2000, 14'h1},
      {14'h1555, 14'h2aaa}};
    foreach (t[i])
    begin
      i_ctrl.write(PLL_DIVIDER_MODULI, t[i]);
      check("ref", ref_div, t[i][13:0]);
      check("fb", fb_div, t[i][27:14]);
    end
    rd(PLL_DIVIDER_MODULI, 1, {t[2], 4'ha});
    i_ctrl.write(4'hb, 28'hfffffff);
    check("ignored", fb_div, 14'h1555);
    check("ignored ref", ref_div, 14'h2aaa);
    rd(4'hb, 0, 32'h0);
    $display("dividers done");
  endtask : test_dividers
  task automatic test_modes();
    logic [1:0] b;
    for (int k = 0; k < 8; k++)
    begin
      b = k < 4 ? BUF_SINGLE : BUF_LOW_SWING;
      i_ctrl.write(OUT9_REG_ADDR, {f9(2'(k), 2'(3 - k), b), 22'h0});
      check("btype", btype, b);
      check("se", se, b == BUF_SINGLE);
      check("ls", ls, b == BUF_LOW_SWING);
      check("pos", pos, pin(2'(k), k < 4));
      check("neg", neg, pin(2'(3 - k), k < 4));
    end
    rd(OUT9_REG_ADDR, 1, {f9(3, 0, b), 26'h9});
    i_ctrl.write(OUT9_REG_ADDR, {6'h01, 22'h0});
    check("pos inv", pos, 3'h6);
    check("neg act", neg, 3'h4);
    $display("modes done");
  endtask : test_modes
  task automatic test_load();
    nv_ref = 14'h2345;
    nv_fb = 14'h0abc;
    nv_o9 = f9(PIN_INVERT, PIN_LOW, BUF_SINGLE);
    fork
      i_ctrl.write(PLL_DIVIDER_MODULI, 28'h1);
      begin
        @(negedge sys_clk);
        nv_load = 1'b1;
        @(negedge sys_clk);
        nv_load = 1'b0;
      end
    join
    check("nv ref", ref_div, 14'h2345);
    check("nv fb", fb_div, 14'h0abc);
    check("nv pos", pos, 3'h6);
    check("nv neg", neg, 3'h1);
    $display("load done");
  endtask : test_load
  task automatic test_reset();
    @(negedge sys_clk);
    rst_b = 1'b0;
    @(negedge sys_clk);
    check("rst ref", ref_div, REF_DIV_RST);
    check("rst fb", fb_div, FB_DIV_RST);
    check("rst type", btype, BUF_TYPE_RST);
    check("rst neg", neg, 3'h4);
    check("rst ack", ack, 0);
    rst_b = 1'b1;
    i_ctrl.write(PLL_DIVIDER_MODULI, 28'h0004001);
    check("post ref", ref_div, 14'h1);
    check("post fb", fb_div, 14'h1);
    $display("reset done");
  endtask : test_reset
  initial
  begin
    rst_b = 1'b0;
    nv_load = 1'b0;
    nv_ref = 14'h0;
    nv_fb = 14'h0;
    nv_o9 = 6'h0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    check("rst pos", pos, 3'h4);
    check("rst neg0", neg, 3'h4);
    test_dividers();
    test_modes();
    test_load();
    test_reset();
    give_verdict();
  end
endmodule : pll_divider_config_regs_tb
`default_nettype wire
